// [rtl/i2cop_defs.svh]
`ifndef I2COP_DEFS_SVH
`define I2COP_DEFS_SVH

// fixed upper three address bits
`define I2COP_ADDR_FIXED 3'h5
// level code of an address select pin: 0 ground, 1 supply, 2 scl, 3 sda
`define I2COP_LVL_GND 2'h0
// read/write bit position in the address byte
`define I2COP_RW_BIT 0
// last bit index of a byte
`define I2COP_LAST_BIT 3'h7
// cycles of por release before power-up defaults are taken
// one edge more than the synchroniser depth, so the select pins are settled when read
`define I2COP_POR_WAIT 2'h3

`endif

// [rtl/i2cop_pkg.sv]
`default_nettype none

package i2cop_pkg;

    typedef enum logic [2:0] {
        I2COP_IDLE = 3'b000,
        I2COP_ADDR = 3'b001,
        I2COP_ADDR_ACK = 3'b010,
        I2COP_WR_DATA = 3'b011,
        I2COP_WR_ACK = 3'b100,
        I2COP_RD_DATA = 3'b101,
        I2COP_RD_ACK = 3'b110,
        I2COP_IGNORE = 3'b111
    } i2cop_state_e;

    typedef logic [7:0] i2cop_byte_t;

endpackage : i2cop_pkg

`default_nettype wire

// [rtl/i2cop_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module i2cop_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // first stage feeds the second stage only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '1;
            sync_out <= '1;
        end else if (ce) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : i2cop_sync

`default_nettype wire

// [rtl/i2cop_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "i2cop_defs.svh"

module i2cop_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [1:0] addr_sel_low_pin,
    input wire logic [1:0] addr_sel_high_pin,
    input wire logic [7:0] output_port_pins_in,
    output logic [7:0] output_port_pins
);

    ////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    function automatic logic addr_match(input logic [6:0] addr, input logic [1:0] lo, input logic [1:0] hi);
        addr_match = (addr == {`I2COP_ADDR_FIXED, hi, lo});
    endfunction : addr_match

    // anything but a ground connection selects high
    function automatic logic [3:0] pwrup_nibble(input logic [1:0] lvl);
        pwrup_nibble = (lvl == `I2COP_LVL_GND) ? 4'h0 : 4'hf;
    endfunction : pwrup_nibble

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic scl_s;
    logic sda_s;
    logic [7:0] pins_s;
    logic [1:0] sel_lo_s;
    logic [1:0] sel_hi_s;

    i2cop_sync #(.WIDTH(14)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .async_in({scl_in, sda_in, output_port_pins_in, addr_sel_low_pin, addr_sel_high_pin}),
        .sync_out({scl_s, sda_s, pins_s, sel_lo_s, sel_hi_s})
    );

    logic scl_d_r;
    logic sda_d_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (ce) begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = ce && scl_s && !scl_d_r;
    assign scl_fall = ce && !scl_s && scl_d_r;
    assign start_det = ce && scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_det = ce && scl_s && scl_d_r && !sda_d_r && sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // serial engine

    i2cop_pkg::i2cop_state_e state_r;
    i2cop_pkg::i2cop_byte_t shift_r;
    i2cop_pkg::i2cop_byte_t tx_r;
    i2cop_pkg::i2cop_byte_t sample_r;
    logic [2:0] bit_r;
    logic rw_r;
    logic nack_r;
    logic sda_oe_n_r;
    logic wr_load;
    logic addr_wait_r;

    assign sda_out = 1'b0;
    assign sda_oe_n = sda_oe_n_r;
    assign wr_load = scl_fall && (state_r == i2cop_pkg::I2COP_WR_DATA) && (bit_r == `I2COP_LAST_BIT);

    // rst_n drops the transfer back to idle, as after a stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= i2cop_pkg::I2COP_IDLE;
            bit_r <= 3'h0;
            rw_r <= 1'b0;
            sda_oe_n_r <= 1'b1;
            tx_r <= 8'h00;
            addr_wait_r <= 1'b0;
        end else if (start_det) begin
            state_r <= i2cop_pkg::I2COP_ADDR;
            bit_r <= 3'h0;
            addr_wait_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
        end else if (stop_det) begin
            state_r <= i2cop_pkg::I2COP_IDLE;
            sda_oe_n_r <= 1'b1;
        end else if (scl_fall) begin
            unique case (state_r)
                i2cop_pkg::I2COP_IDLE, i2cop_pkg::I2COP_IGNORE: begin
                    sda_oe_n_r <= 1'b1;
                end
                i2cop_pkg::I2COP_ADDR: begin
                    if (bit_r == `I2COP_LAST_BIT) begin
                        rw_r <= shift_r[`I2COP_RW_BIT];
                        if (addr_match(shift_r[7:1], sel_lo_s, sel_hi_s)) begin
                            state_r <= i2cop_pkg::I2COP_ADDR_ACK;
                            sda_oe_n_r <= 1'b0;
                        end else begin
                            state_r <= i2cop_pkg::I2COP_IGNORE;
                        end
                    end
                    // the scl fall that closes a start carries no bit
                    if (addr_wait_r) begin
                        addr_wait_r <= 1'b0;
                    end else begin
                        bit_r <= bit_r + 3'h1;
                    end
                end
                i2cop_pkg::I2COP_ADDR_ACK: begin
                    bit_r <= 3'h0;
                    if (rw_r) begin
                        state_r <= i2cop_pkg::I2COP_RD_DATA;
                        tx_r <= {sample_r[6:0], 1'b1};
                        sda_oe_n_r <= sample_r[7];
                    end else begin
                        state_r <= i2cop_pkg::I2COP_WR_DATA;
                        sda_oe_n_r <= 1'b1;
                    end
                end
                i2cop_pkg::I2COP_WR_DATA: begin
                    if (bit_r == `I2COP_LAST_BIT) begin
                        state_r <= i2cop_pkg::I2COP_WR_ACK;
                        sda_oe_n_r <= 1'b0;
                    end
                    bit_r <= bit_r + 3'h1;
                end
                i2cop_pkg::I2COP_WR_ACK: begin
                    state_r <= i2cop_pkg::I2COP_WR_DATA;
                    sda_oe_n_r <= 1'b1;
                end
                i2cop_pkg::I2COP_RD_DATA: begin
                    if (bit_r == `I2COP_LAST_BIT) begin
                        state_r <= i2cop_pkg::I2COP_RD_ACK;
                        sda_oe_n_r <= 1'b1;
                    end else begin
                        sda_oe_n_r <= tx_r[7];
                        tx_r <= {tx_r[6:0], 1'b1};
                    end
                    bit_r <= bit_r + 3'h1;
                end
                i2cop_pkg::I2COP_RD_ACK: begin
                    bit_r <= 3'h0;
                    if (nack_r) begin
                        state_r <= i2cop_pkg::I2COP_IGNORE;
                        sda_oe_n_r <= 1'b1;
                    end else begin
                        state_r <= i2cop_pkg::I2COP_RD_DATA;
                        tx_r <= {sample_r[6:0], 1'b1};
                        sda_oe_n_r <= sample_r[7];
                    end
                end
            endcase
        end
    end

    // receive shifter and master acknowledge capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= 8'h00;
            nack_r <= 1'b0;
        end else if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            if (state_r == i2cop_pkg::I2COP_RD_ACK) begin
                nack_r <= sda_s;
            end
        end
    end

    // live pin levels, so a forced pin reads back as forced
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_r <= 8'h00;
        end else if (scl_rise && (state_r == i2cop_pkg::I2COP_ADDR_ACK || state_r == i2cop_pkg::I2COP_RD_ACK)) begin
            sample_r <= pins_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output register: only por_n clears it, rst_n leaves it alone

    logic [1:0] por_cnt_r;

    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            por_cnt_r <= 2'h0;
            output_port_pins <= 8'h00;
        end else if (ce) begin
            if (por_cnt_r != `I2COP_POR_WAIT) begin
                // wait for select pins to pass the synchroniser
                por_cnt_r <= por_cnt_r + 2'h1;
                if (por_cnt_r + 2'h1 == `I2COP_POR_WAIT) begin
                    output_port_pins <= {pwrup_nibble(sel_hi_s), pwrup_nibble(sel_lo_s)};
                end
            end else if (wr_load) begin
                output_port_pins <= shift_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_addr_foreign:
    assert property (@(posedge clk) disable iff (!rst_n)
        (scl_fall && !start_det && !stop_det && state_r == i2cop_pkg::I2COP_ADDR && bit_r == 3'h7
         && !addr_match(shift_r[7:1], sel_lo_s, sel_hi_s))
        |=> sda_oe_n && state_r == i2cop_pkg::I2COP_IGNORE)
        else $error("foreign address was not ignored");

    a_addr_ack_drive:
    assert property (@(posedge clk) disable iff (!rst_n)
        (scl_fall && !start_det && !stop_det && state_r == i2cop_pkg::I2COP_ADDR && bit_r == 3'h7
         && addr_match(shift_r[7:1], sel_lo_s, sel_hi_s))
        |=> !sda_oe_n && state_r == i2cop_pkg::I2COP_ADDR_ACK)
        else $error("own address not acknowledged");

    a_write_update:
    assert property (@(posedge clk) disable iff (!rst_n || !por_n)
        (wr_load && !start_det && !stop_det && por_cnt_r == `I2COP_POR_WAIT)
        |=> output_port_pins == $past(shift_r) && !sda_oe_n)
        else $error("write byte not applied or not acknowledged");

    a_write_ack_release:
    assert property (@(posedge clk) disable iff (!rst_n)
        (scl_fall && !start_det && !stop_det && state_r == i2cop_pkg::I2COP_WR_ACK)
        |=> sda_oe_n && state_r == i2cop_pkg::I2COP_WR_DATA && bit_r == 3'h0)
        else $error("write ack not released");

    a_read_first_byte:
    assert property (@(posedge clk) disable iff (!rst_n)
        (scl_fall && !start_det && !stop_det && state_r == i2cop_pkg::I2COP_ADDR_ACK && rw_r)
        |=> sda_oe_n == $past(sample_r[7]) && tx_r[7:1] == $past(sample_r[6:0]))
        else $error("read byte not taken from pin sample");

    a_read_resample:
    assert property (@(posedge clk) disable iff (!rst_n)
        (scl_rise && !start_det && !stop_det && state_r == i2cop_pkg::I2COP_RD_ACK)
        |=> sample_r == $past(pins_s))
        else $error("pins not resampled at master ack");

    a_read_nack_stop:
    assert property (@(posedge clk) disable iff (!rst_n)
        (scl_fall && !start_det && !stop_det && state_r == i2cop_pkg::I2COP_RD_ACK && nack_r)
        |=> sda_oe_n [*2])
        else $error("sda driven after master nack");

    a_read_bit_drive:
    assert property (@(posedge clk) disable iff (!rst_n)
        (scl_fall && !start_det && !stop_det && state_r == i2cop_pkg::I2COP_RD_DATA && bit_r != 3'h7)
        |=> sda_oe_n == $past(tx_r[7]))
        else $error("read bit not driven from shifter");

    a_stop_idle:
    assert property (@(posedge clk) disable iff (!rst_n)
        (stop_det && !start_det) |=> state_r == i2cop_pkg::I2COP_IDLE && sda_oe_n && $stable(output_port_pins))
        else $error("stop did not return to idle");

endmodule : i2cop_top

`default_nettype wire

// [testbench/i2cop_master.sv]
`timescale 1ns/1ns
`default_nettype none

module i2cop_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic pull
);
    // scl stands high outside frames; low phase 5 clk, high phase 3 clk
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end

    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w

    task automatic start();
        w(1);
        pull = 1'b0;
        w(4);
        scl = 1'b1;
        w(4);
        pull = 1'b1;
        w(4);
        scl = 1'b0;
    endtask : start

    task automatic stop();
        w(1);
        pull = 1'b1;
        w(4);
        scl = 1'b1;
        w(4);
        pull = 1'b0;
        w(4);
    endtask : stop

    // data moves one clk after the fall so it never races the device's answer
    task automatic bit_x(input logic b, output logic r);
        w(1);
        pull = ~b;
        w(4);
        scl = 1'b1;
        w(2);
        r = sda;
        w(1);
        scl = 1'b0;
    endtask : bit_x

    task automatic xfer(input logic [7:0] tx, input logic ackb, output logic [7:0] rx, output logic ackr);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(ackb, ackr);
    endtask : xfer
endmodule : i2cop_master

`default_nettype wire

// [testbench/i2cop_top_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "i2cop_defs.svh"

module i2cop_top_tb_top;
    logic clk;
    logic rst_n;
    logic por_n;
    logic scl;
    logic pull;
    logic sda_line;
    logic sda_out;
    logic sda_oe_n;
    logic [1:0] sel_lo;
    logic [1:0] sel_hi;
    logic [7:0] frc;
    logic [7:0] pins;
    logic [7:0] rx;
    logic [6:0] adr;
    logic ack;
    int err_total;
    int compares;

    // open-drain line with pull-up; frc models an outside source fighting a pin
    assign sda_line = ~pull & (sda_oe_n | sda_out);
    assign adr = {`I2COP_ADDR_FIXED, sel_hi, sel_lo};

    i2cop_top dut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .ce(1'b1), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel_low_pin(sel_lo), .addr_sel_high_pin(sel_hi),
        .output_port_pins_in(pins ^ frc), .output_port_pins(pins));

    i2cop_master m (.clk(clk), .sda(sda_line), .scl(scl), .pull(pull));

    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    ////////////////////////////////////////////////////////////////
    task automatic t_write_multi();
        logic [7:0] d [3] = '{8'ha5, 8'h5a, 8'h01};
        m.start();
        m.xfer({adr, 1'b0}, 1'b1, rx, ack);
        check("wr addr ack", {7'h0, ack}, 8'h00);
        foreach (d[i]) begin
            m.xfer(d[i], 1'b1, rx, ack);
            check("wr data ack", {7'h0, ack}, 8'h00);
            check("pins per byte", pins, d[i]);
        end
        m.stop();
        check("pins last byte", pins, 8'h01);
        m.start();
        m.xfer({adr, 1'b0}, 1'b1, rx, ack);
        m.xfer(8'h3c, 1'b1, rx, ack);
        check("single ack", {7'h0, ack}, 8'h00);
        m.stop();
        check("single byte", pins, 8'h3c);
    endtask : t_write_multi

    task automatic t_read_multi();
        frc = 8'h00;
        m.start();
        m.xfer({adr, 1'b1}, 1'b1, rx, ack);
        check("rd addr ack", {7'h0, ack}, 8'h00);
        frc = 8'h81;
        m.xfer(8'hff, 1'b0, rx, ack);
        check("rd byte0", rx, 8'h3c);
        frc = 8'h0f;
        m.xfer(8'hff, 1'b0, rx, ack);
        check("rd byte1", rx, 8'hbd);
        m.xfer(8'hff, 1'b1, rx, ack);
        check("rd byte2", rx, 8'h33);
        m.xfer(8'hff, 1'b1, rx, ack);
        check("after nack", rx, 8'hff);
        m.stop();
        frc = 8'h00;
    endtask : t_read_multi

    task automatic t_reset_abort();
        m.start();
        m.xfer({adr, 1'b1}, 1'b1, rx, ack);
        m.bit_x(1'b1, ack);
        m.w(5);
        // device now pulls for a zero bit, so the abort must release it
        check("driving", {7'h0, sda_oe_n}, 8'h00);
        rst_n = 1'b0;
        m.w(2);
        check("rst release", {7'h0, sda_oe_n}, 8'h01);
        check("rst keeps pins", pins, 8'h3c);
        rst_n = 1'b1;
        m.w(4);
        m.stop();
    endtask : t_reset_abort

    task automatic t_foreign();
        m.start();
        m.xfer({adr ^ 7'h01, 1'b0}, 1'b1, rx, ack);
        check("foreign nack", {7'h0, ack}, 8'h01);
        m.xfer(8'h00, 1'b1, rx, ack);
        check("foreign data", {7'h0, ack}, 8'h01);
        m.stop();
        check("foreign pins", pins, 8'h3c);
    endtask : t_foreign

    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // whole sequence is near 1200 clk; watchdog leaves wide margin
    initial begin
        #400000;
        err_total++;
        give_verdict();
    end

    initial begin
        err_total = 0;
        compares = 0;
        rst_n = 1'b0;
        por_n = 1'b0;
        sel_lo = 2'h0;
        sel_hi = 2'h1;
        frc = 8'h00;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        por_n = 1'b1;
        repeat (8) @(negedge clk);
        check("power-up", pins, 8'hf0);
        t_write_multi();
        t_read_multi();
        t_reset_abort();
        t_foreign();
        give_verdict();
    end
endmodule : i2cop_top_tb_top

`default_nettype wire
